// file: common/gpio_pin_regs.vh
`ifndef GPIO_PIN_REGS_VH
`define GPIO_PIN_REGS_VH

// byte addresses on the register bus
`define PIN_ENABLE_ADDR 32'h01b00000
`define PIN_DIRECTION_ADDR 32'h01b00004
`define PIN_OUTPUT_ADDR 32'h01b00008
`define PIN_LEVEL_ADDR 32'h01b0000c

// field layout: sixteen pins in bits 15..0, 31..16 reserved
`define PIN_FIELD_MSB 15
`define PIN_FIELD_LSB 0
`define PIN_COUNT 16

// shared pads with the host port data pins
`define SHARED_PAD_MSB 15
`define SHARED_PAD_LSB 9
`define SHARED_PAD_COUNT 7

// reset values
`define PIN_ENABLE_RESET 16'h0000
`define PIN_DIRECTION_RESET 16'h0000
`define PIN_OUTPUT_RESET 16'h0000
`define HOST_PORT_EN_RESET 1'h1

`endif

// file: logic/gpio_pin_enable_direction.v
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "gpio_pin_regs.vh"

// Notes on behaviour
// - pads 15..9 shared between general pins and host port data pins, one pad each.
// - shared pads default to the host port function after reset.
// - host port strap sampled at reset; low enables, high disables; fixed afterwards.
// - sixteen general pins, each with its own enable and direction bit.
// - a pin acts as general I/O only while its enable bit is one.
// - direction zero makes the pin an input, one makes it an output.
// - direction bit matters only while the matching enable bit is set.
// - direction register resets to zero, all pins inputs.
// - enable register at 01B0 0000, bits 15..0, upper half reserved.
// - direction register at 01B0 0004, one bit per pin.
module gpio_pin_enable_direction (
	// clock and reset
	input wire CLK_IN,
	input wire RST_N_IN,
	// wishbone slave
	input wire WB_CYC_IN,
	input wire WB_STB_IN,
	input wire WB_WE_IN,
	input wire [31:0] WB_ADR_IN,
	input wire [3:0] WB_SEL_IN,
	input wire [31:0] WB_DAT_IN,
	output reg [31:0] WB_DAT_OUT,
	output reg WB_ACK_OUT,
	// general pin bank pads
	input wire [15:0] GP_PAD_IN,
	output reg [15:0] GP_PAD_OUT,
	output reg [15:0] GP_PAD_OE_N_OUT,
	// host port side of the shared pads
	input wire [6:0] HP_DATA_TO_PAD_IN,
	input wire [6:0] HP_DATA_OE_IN,
	output reg [6:0] HP_DATA_FROM_PAD_OUT,
	// host port strap
	input wire HOST_STRAP_IN,
	output reg HOST_PORT_EN_OUT
);

	function [15:0] merge_bytes;
		input [15:0] old_val;
		input [15:0] new_val;
		input [1:0] sel;
		begin
			merge_bytes = old_val;
			if (sel[0]) begin
				merge_bytes[7:0] = new_val[7:0];
			end
			if (sel[1]) begin
				merge_bytes[15:8] = new_val[15:8];
			end
		end
	endfunction

	function hit;
		input [31:0] adr;
		input [31:0] target;
		begin
			hit = (adr[31:2] == target[31:2]);
		end
	endfunction

	reg [15:0] pin_enable_q;
	reg [15:0] pin_direction_q;
	reg [15:0] pin_output_q;
	reg [15:0] pad_s1_q;
	reg [15:0] pad_s2_q;
	reg [15:0] pad_s3_q;
	reg [15:0] pad_level_q;
	reg [15:0] pad_level_d;
	reg strap_s1_q;
	reg strap_s2_q;
	reg strap_s3_q;
	reg strap_done_q;
	reg [31:0] rd_d;
	reg [15:0] pad_out_d;
	reg [15:0] pad_oe_n_d;
	wire req;
	wire wr_commit;
	integer i;

	assign req = WB_CYC_IN & WB_STB_IN;
	// write lands on the edge where the master sees ack
	assign wr_commit = req & WB_WE_IN & WB_ACK_OUT;

	// pad and strap synchronisers, no reset so the strap settles while reset is held
	always @(posedge CLK_IN) begin
		pad_s1_q <= GP_PAD_IN;
		pad_s2_q <= pad_s1_q;
		pad_s3_q <= pad_s2_q;
		strap_s1_q <= HOST_STRAP_IN;
		strap_s2_q <= strap_s1_q;
		strap_s3_q <= strap_s2_q;
	end

	// a bit changes only once stages two and three agree
	always @* begin
		pad_level_d = ((pad_s2_q ~^ pad_s3_q) & pad_s3_q) |
			(~(pad_s2_q ~^ pad_s3_q) & pad_level_q);
	end

	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			pad_level_q <= 16'h0000;
			// host port owns pads by default
			HOST_PORT_EN_OUT <= `HOST_PORT_EN_RESET;
			strap_done_q <= 1'b0;
		end else begin
			pad_level_q <= pad_level_d;
			if (!strap_done_q && (strap_s2_q == strap_s3_q)) begin
				HOST_PORT_EN_OUT <= ~strap_s3_q;
				strap_done_q <= 1'b1;
			end
		end
	end

	// register writes
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			pin_enable_q <= `PIN_ENABLE_RESET;
			pin_direction_q <= `PIN_DIRECTION_RESET;
			pin_output_q <= `PIN_OUTPUT_RESET;
		end else if (wr_commit) begin
			if (hit(WB_ADR_IN, `PIN_ENABLE_ADDR)) begin
				pin_enable_q <= merge_bytes(pin_enable_q, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
			end
			if (hit(WB_ADR_IN, `PIN_DIRECTION_ADDR)) begin
				pin_direction_q <= merge_bytes(pin_direction_q, WB_DAT_IN[15:0],
					WB_SEL_IN[1:0]);
			end
			if (hit(WB_ADR_IN, `PIN_OUTPUT_ADDR)) begin
				pin_output_q <= merge_bytes(pin_output_q, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
			end
		end
	end

	// read mux; unmapped addresses read zero and are still acknowledged
	always @* begin
		rd_d = 32'h00000000;
		if (hit(WB_ADR_IN, `PIN_ENABLE_ADDR)) begin
			rd_d[15:0] = pin_enable_q;
		end
		if (hit(WB_ADR_IN, `PIN_DIRECTION_ADDR)) begin
			rd_d[15:0] = pin_direction_q;
		end
		if (hit(WB_ADR_IN, `PIN_OUTPUT_ADDR)) begin
			rd_d[15:0] = pin_output_q;
		end
		if (hit(WB_ADR_IN, `PIN_LEVEL_ADDR)) begin
			rd_d[15:0] = pad_level_q;
		end
	end

	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			WB_ACK_OUT <= 1'b0;
			WB_DAT_OUT <= 32'h00000000;
		end else begin
			WB_ACK_OUT <= req & ~WB_ACK_OUT;
			if (req & ~WB_ACK_OUT) begin
				WB_DAT_OUT <= rd_d;
			end else begin
				WB_DAT_OUT <= 32'h00000000;
			end
		end
	end

	// pad multiplexer, registered so pads never glitch on decode
	always @* begin
		pad_out_d = 16'h0000;
		pad_oe_n_d = 16'hffff;
		for (i = 0; i < `PIN_COUNT; i = i + 1) begin
			if (pin_enable_q[i]) begin
				pad_out_d[i] = pin_output_q[i];
				pad_oe_n_d[i] = ~pin_direction_q[i];
			end else if (i >= `SHARED_PAD_LSB) begin
				// upper seven pads shared with host port
				// host port takes pads not claimed
				pad_out_d[i] = HP_DATA_TO_PAD_IN[i - `SHARED_PAD_LSB];
				pad_oe_n_d[i] = ~(HOST_PORT_EN_OUT & HP_DATA_OE_IN[i - `SHARED_PAD_LSB]);
			end
		end
	end

	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			GP_PAD_OUT <= 16'h0000;
			GP_PAD_OE_N_OUT <= 16'hffff;
			HP_DATA_FROM_PAD_OUT <= 7'h00;
		end else begin
			GP_PAD_OUT <= pad_out_d;
			GP_PAD_OE_N_OUT <= pad_oe_n_d;
			// host port sees pad only while it owns it
			HP_DATA_FROM_PAD_OUT <= pad_level_q[`SHARED_PAD_MSB:`SHARED_PAD_LSB] &
				~pin_enable_q[`SHARED_PAD_MSB:`SHARED_PAD_LSB];
		end
	end

endmodule

// file: tb/board_pads.sv
`timescale 1ns/1ps
module board_pads(
	input wire logic [15:0] DRIVE_IN, OE_N_IN, BOARD_IN,
	output logic [15:0] LEVEL_OUT);
	assign LEVEL_OUT = (~OE_N_IN & DRIVE_IN) | (OE_N_IN & BOARD_IN);
endmodule

// file: tb/gpio_pin_enable_direction_asserts.sv
`timescale 1ns/1ps
module gpio_chk(
	input wire logic CLK_IN, RST_N_IN, WB_CYC_IN, WB_STB_IN, WB_WE_IN, WB_ACK_OUT,
	input wire logic [31:0] WB_ADR_IN, WB_DAT_OUT,
	input wire logic HOST_STRAP_IN, HOST_PORT_EN_OUT);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	chk_ack_next: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
		else $error("ack late");
	chk_ack_drop: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack held");
	chk_ack_cause: assert property ($rose(WB_ACK_OUT) |-> $past(WB_STB_IN))
		else $error("ack unasked");
	chk_dat_idle: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 0) else $error("data idle");
	chk_rsvd_zero: assert property (WB_ACK_OUT && !WB_WE_IN |-> WB_DAT_OUT[31:16] == 0)
		else $error("upper half");
	chk_unmapped_zero: assert property (WB_ACK_OUT && WB_ADR_IN[31:4] != 28'h01b0000
		|-> WB_DAT_OUT == 0) else $error("unmapped");
	chk_strap_take: assert property ($rose(RST_N_IN) |=> HOST_PORT_EN_OUT == !$past(HOST_STRAP_IN))
		else $error("strap");
	chk_strap_hold: assert property ($past(RST_N_IN) && $past(RST_N_IN, 2)
		|-> $stable(HOST_PORT_EN_OUT)) else $error("strap moved");
	cover property (WB_ACK_OUT && WB_WE_IN);
	cover property (WB_ACK_OUT && !WB_WE_IN);
	cover property (!HOST_PORT_EN_OUT);
endmodule
bind gpio_pin_enable_direction gpio_chk u_chk(.CLK_IN, .RST_N_IN, .WB_CYC_IN, .WB_STB_IN,
	.WB_WE_IN, .WB_ACK_OUT, .WB_ADR_IN, .WB_DAT_OUT, .HOST_STRAP_IN, .HOST_PORT_EN_OUT);

// file: tb/gpio_pin_enable_direction_tb.sv
`timescale 1ns/1ps
module gpio_pin_enable_direction_tb;
	logic CLK_IN = 0, RST_N_IN = 0, cyc = 0, we = 0, strap = 0, ack, hpen;
	logic [31:0] adr = 0, wd = 0, rdat, q[$];
	logic [15:0] pad, po, oe, drv = 0;
	logic [6:0] hpd = 0, hpoe = 0, hpin;
	integer n_errors = 0, checked = 0, seed = 32'h2ff785b1, ticks = 0;
	initial forever #50 CLK_IN = ~CLK_IN;
	gpio_pin_enable_direction dut(.CLK_IN, .RST_N_IN, .WB_CYC_IN(cyc), .WB_STB_IN(cyc),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wd), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .GP_PAD_IN(pad), .GP_PAD_OUT(po), .GP_PAD_OE_N_OUT(oe),
		.HP_DATA_TO_PAD_IN(hpd), .HP_DATA_OE_IN(hpoe), .HP_DATA_FROM_PAD_OUT(hpin),
		.HOST_STRAP_IN(strap), .HOST_PORT_EN_OUT(hpen));
	board_pads board(.DRIVE_IN(po), .OE_N_IN(oe), .BOARD_IN(drv), .LEVEL_OUT(pad));
	task chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (e !== g) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task final_report;
		if (n_errors == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task wb(input logic w, input logic [31:0] a, d);
		@(posedge CLK_IN);
		cyc <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		@(posedge CLK_IN);
		while (ack !== 1) @(posedge CLK_IN);
		cyc <= 0;
	endtask
	task rd(input logic [31:0] a, e);
		q.push_back(e);
		wb(0, a, 0);
	endtask
	always @(posedge CLK_IN) begin
		if (ack && !we) chk("read", q.pop_front(), rdat);
		ticks++;
		if (ticks > 2000) begin
			n_errors++;
			final_report;
		end
	end
	task run(input logic hp);
		logic [15:0] en, dir, o, e_oe, e_po, lvl;
		en = 16'($random(seed));
		dir = 16'($random(seed));
		o = 16'($random(seed));
		drv <= 16'($random(seed));
		{hpd, hpoe} <= 14'($random(seed));
		wb(1, 32'h01b00000, {16'hffff, en});
		wb(1, 32'h01b00004, {16'hffff, dir});
		wb(1, 32'h01b00008, {16'h0, o});
		rd(32'h01b00000, {16'h0, en}); // enable bits
		rd(32'h01b00004, {16'h0, dir}); // direction bits
		e_oe = ~((en & dir) | (~en & {hpoe & {7{hp}}, 9'h0}));
		e_po = (en & o) | (~en & {hpd, 9'h0});
		lvl = (~e_oe & e_po) | (e_oe & drv);
		chk("oe", e_oe, oe); // pad owner
		chk("pad", e_po, po); // pad value
		rd(32'h01b0000c, {16'h0, lvl});
		chk("host", lvl[15:9] & ~en[15:9], hpin); // shared pads
	endtask
	initial begin
		repeat (2) @(posedge CLK_IN);
		RST_N_IN <= 1;
		rd(32'h01b00000, 0); // host owns pads
		rd(32'h01b00004, 0); // all inputs
		rd(32'h01b00010, 0);
		chk("oe", 16'hffff, oe); // all inputs
		chk("strap", 1, hpen); // strap low
		repeat (4) run(1);
		RST_N_IN <= 0;
		strap <= 1;
		repeat (5) @(posedge CLK_IN);
		RST_N_IN <= 1;
		@(posedge CLK_IN);
		strap <= 0;
		repeat (4) run(0);
		chk("strap", 0, hpen); // fixed after reset
		final_report;
	end
endmodule
